//--- logic/adc_seq_pkg.sv
package adc_seq_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register map: one byte per address
  localparam logic [2:0] OFS_RESULT_LOW = 3'h0;
  localparam logic [2:0] OFS_RESULT_HIGH = 3'h1;
  localparam logic [2:0] OFS_CONV_CONTROL = 3'h2;
  localparam logic [2:0] OFS_CLOCK_POWER_SELECT = 3'h3;
  localparam logic [2:0] OFS_IRQ_CONTROL = 3'h4;
  localparam logic [2:0] OFS_IRQ_STATUS = 3'h5;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h6;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CC_CHAN_LSB = 0;
  localparam int CC_BUSY_BIT = 3;
  localparam int CC_START_BIT = 4;
  localparam int CC_PIN_LSB = 5;
  localparam int CP_DIV_LSB = 0;
  localparam int CP_PD_BIT = 7;
  localparam int IC_GLOBAL_BIT = 0;
  localparam int IC_MULTI_BIT = 1;
  localparam int IS_CONV_BIT = 0;

  // Reset values
  localparam logic RST_POWER_DOWN = 1'b1;
  localparam logic RST_BUSY = 1'b0;
  localparam logic [2:0] RST_DIV = 3'h0;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Converter geometry and timing
  localparam int NUM_CHANNELS = 8;
  localparam int RESULT_W = 12;
  localparam logic [4:0] CONV_TICKS = 5'h10;
  localparam logic [4:0] SAMPLE_TICKS = 5'h04;
  localparam logic [2:0] PIN_ALL = 3'h7;
  localparam logic [3:0] PIN_BASE_COUNT = 4'h3;

  // Conversion clock ratios, indexed by the divider code
  localparam logic [5:0] DIV_CODE0 = 6'h02;
  localparam logic [5:0] DIV_CODE1 = 6'h08;
  localparam logic [5:0] DIV_CODE2 = 6'h20;
  localparam logic [5:0] DIV_CODE3 = 6'h20;
  localparam logic [5:0] DIV_CODE4 = 6'h01;
  localparam logic [5:0] DIV_CODE5 = 6'h04;
  localparam logic [5:0] DIV_CODE6 = 6'h10;
  localparam logic [5:0] DIV_CODE7 = 6'h20;

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HOLD = 3'b010,
    ST_CONV = 3'b100
  } seq_state_e;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic [7:0] pullReq;
    logic [7:0] dirInReq;
  } port_req_s;

  typedef struct packed {
    logic [7:0] analogMask;
    logic [7:0] pullEn;
    logic [7:0] dirIn;
  } port_ctl_s;

  typedef struct packed {
    logic powerOn;
    logic convReset;
    logic sample;
    logic [7:0] chanSel;
    logic [11:0] dacCode;
  } core_ctl_s;

  typedef struct packed {
    seq_state_e state;
    logic [2:0] chan;
    logic [2:0] pinCfg;
    logic start;
    logic busy;
    logic powerDown;
    logic [2:0] divSel;
    logic globalEn;
    logic multiEn;
    logic [7:0] irqStat;
    logic [7:0] irqMask;
    logic [11:0] result;
    logic [11:0] sar;
    logic [5:0] divCnt;
    logic [4:0] tickCnt;
    logic sample;
    logic [7:0] rdata;
    logic compMeta;
    logic compSync;
  } seq_regs_s;

endpackage : adc_seq_pkg

//--- logic/adc_sequencer_control.sv
// Function
// - One converter, eight inputs, 12-bit result
// - Result split: high byte 11..4, low nibble
// - Three-bit field picks one input channel
// - Pin field sets analog pins; 111 all
// - Pin field zero: digital pins, converter off
// - Start raised then lowered begins conversion
// - Start held high: converter reset, busy set
// - Busy flag clears when conversion completes
// - Completion sets interrupt flag, may interrupt
// - Three-bit divider sets conversion clock ratio
// - Converter on: power bit low, pins nonzero
// - Analog pins: pull-ups off, direction overridden
// - Interrupt needs global, group, converter enables
// - Conversion lasts sixteen conversion clock periods
`timescale 1ns/100ps
module adc_sequencer_control
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire reg_req_s busReq,
  output logic [7:0] busRdata,
  input wire port_req_s portReq,
  output port_ctl_s portCtl,
  output core_ctl_s coreCtl,
  input wire logic compHigh,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [5:0] div_ratio(input logic [2:0] code);
    logic [5:0] r;
    r = DIV_CODE0;
    case (code)
      3'h0: begin
        r = DIV_CODE0;
      end
      3'h1: begin
        r = DIV_CODE1;
      end
      3'h2: begin
        r = DIV_CODE2;
      end
      // Undefined code: treated as the slowest ratio
      3'h3: begin
        r = DIV_CODE3;
      end
      3'h4: begin
        r = DIV_CODE4;
      end
      3'h5: begin
        r = DIV_CODE5;
      end
      3'h6: begin
        r = DIV_CODE6;
      end
      default: begin
        r = DIV_CODE7;
      end
    endcase
    return r;
  endfunction : div_ratio

  // Codes 1 to 4 enable a growing group starting at pin 0, codes 5 to 7 all pins
  function automatic logic [7:0] pin_mask(input logic [2:0] cfg);
    logic [7:0] m;
    logic [3:0] n;
    m = 8'h00;
    n = 4'h0;
    if (cfg == PIN_ALL) begin
      m = 8'hff;
    end else if (cfg != 3'h0) begin
      n = {1'b0, cfg} + PIN_BASE_COUNT;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        if (4'(i) < n) begin
          m[i] = 1'b1;
        end
      end
    end
    return m;
  endfunction : pin_mask

  //////////////////////////////////////////////////////////////////////////////
  // State

  seq_regs_s s_r;
  seq_regs_s s_nxt;

  logic convOn;
  logic tick;
  logic wrCtl;
  logic wrCps;
  logic wrIrqCtl;
  logic wrIrqStat;
  logic wrIrqMask;
  logic irqPending;
  logic startRise;
  logic startFall;
  logic [7:0] ctlWord;
  logic [7:0] cpsWord;
  logic [7:0] irqSet;
  logic [7:0] irqClr;
  logic [7:0] analogMask;

  assign convOn = !s_r.powerDown && (s_r.pinCfg != 3'h0);
  assign tick = (s_r.divCnt == div_ratio(s_r.divSel) - 6'h01);
  // Register strobes; the map has one byte per address
  assign wrCtl = busReq.wr && (busReq.addr == OFS_CONV_CONTROL);
  assign wrCps = busReq.wr && (busReq.addr == OFS_CLOCK_POWER_SELECT);
  assign wrIrqCtl = busReq.wr && (busReq.addr == OFS_IRQ_CONTROL);
  assign wrIrqStat = busReq.wr && (busReq.addr == OFS_IRQ_STATUS);
  assign wrIrqMask = busReq.wr && (busReq.addr == OFS_IRQ_MASK);

  assign startRise = wrCtl && !s_r.start && busReq.wdata[CC_START_BIT];
  assign startFall = wrCtl && s_r.start && !busReq.wdata[CC_START_BIT];
  assign analogMask = pin_mask(s_r.pinCfg);
  assign ctlWord = {s_r.pinCfg, s_r.start, s_r.busy, s_r.chan};
  assign cpsWord = {s_r.powerDown, 4'h0, s_r.divSel};

  always_comb begin
    s_nxt = s_r;
    irqSet = 8'h00;
    irqClr = 8'h00;

    // Comparator is asynchronous to clk: two flops before use
    s_nxt.compMeta = compHigh;
    s_nxt.compSync = s_r.compMeta;

    ////////////////////////////////////////////////////////////////////////////
    // Register writes
    if (wrCtl) begin
      s_nxt.chan = busReq.wdata[CC_CHAN_LSB +: 3];
      s_nxt.pinCfg = busReq.wdata[CC_PIN_LSB +: 3];
      s_nxt.start = busReq.wdata[CC_START_BIT];
    end else if (wrCps) begin
      s_nxt.divSel = busReq.wdata[CP_DIV_LSB +: 3];
      s_nxt.powerDown = busReq.wdata[CP_PD_BIT];
    end else if (wrIrqCtl) begin
      s_nxt.globalEn = busReq.wdata[IC_GLOBAL_BIT];
      s_nxt.multiEn = busReq.wdata[IC_MULTI_BIT];
    end else if (wrIrqStat) begin
      irqClr = busReq.wdata;
    end else if (wrIrqMask) begin
      s_nxt.irqMask = busReq.wdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads: data stands in the following cycle only
    s_nxt.rdata = 8'h00;
    if (busReq.rd) begin
      if (busReq.addr == OFS_RESULT_LOW) begin
        s_nxt.rdata = {s_r.result[3:0], 4'h0};
      end else if (busReq.addr == OFS_RESULT_HIGH) begin
        s_nxt.rdata = s_r.result[11:4];
      end else if (busReq.addr == OFS_CONV_CONTROL) begin
        s_nxt.rdata = ctlWord;
      end else if (busReq.addr == OFS_CLOCK_POWER_SELECT) begin
        s_nxt.rdata = cpsWord;
      end else if (busReq.addr == OFS_IRQ_CONTROL) begin
        s_nxt.rdata = {6'h00, s_r.multiEn, s_r.globalEn};
      end else if (busReq.addr == OFS_IRQ_STATUS) begin
        s_nxt.rdata = s_r.irqStat;
      end else if (busReq.addr == OFS_IRQ_MASK) begin
        s_nxt.rdata = s_r.irqMask;
      end else begin
        s_nxt.rdata = 8'h00;
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion clock divider, free running outside a conversion
    if (tick) begin
      s_nxt.divCnt = 6'h00;
    end else begin
      s_nxt.divCnt = s_r.divCnt + 6'h01;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    case (s_r.state)
      ST_IDLE: begin
        if (startRise) begin
          s_nxt.state = ST_HOLD;
          s_nxt.busy = 1'b1;
        end
      end
      ST_HOLD: begin
        s_nxt.busy = 1'b1;
        s_nxt.sample = 1'b0;
        if (startFall) begin
          if (convOn) begin
            // Restart the divider so sixteen periods count from the pulse
            s_nxt.state = ST_CONV;
            s_nxt.divCnt = 6'h00;
            s_nxt.tickCnt = 5'h00;
            s_nxt.sar = 12'h000;
            s_nxt.sample = 1'b1;
          end else begin
            // Converter off: no completion is ever reported
            s_nxt.state = ST_IDLE;
          end
        end
      end
      ST_CONV: begin
        s_nxt.busy = 1'b1;
        if (startRise) begin
          // A new start pulse aborts the running conversion
          s_nxt.state = ST_HOLD;
          s_nxt.sample = 1'b0;
        end else if (!convOn) begin
          s_nxt.state = ST_IDLE;
          s_nxt.sample = 1'b0;
        end else if (tick) begin
          s_nxt.tickCnt = s_r.tickCnt + 5'h01;
          if (s_r.tickCnt + 5'h01 == SAMPLE_TICKS) begin
            s_nxt.sample = 1'b0;
            s_nxt.sar = 12'h800;
          end else begin
            // Decide the bit on trial, then try the next one down
            case (s_r.tickCnt)
              SAMPLE_TICKS + 5'h00: begin
                s_nxt.sar[11] = s_r.compSync;
                s_nxt.sar[10] = 1'b1;
              end
              SAMPLE_TICKS + 5'h01: begin
                s_nxt.sar[10] = s_r.compSync;
                s_nxt.sar[9] = 1'b1;
              end
              SAMPLE_TICKS + 5'h02: begin
                s_nxt.sar[9] = s_r.compSync;
                s_nxt.sar[8] = 1'b1;
              end
              SAMPLE_TICKS + 5'h03: begin
                s_nxt.sar[8] = s_r.compSync;
                s_nxt.sar[7] = 1'b1;
              end
              SAMPLE_TICKS + 5'h04: begin
                s_nxt.sar[7] = s_r.compSync;
                s_nxt.sar[6] = 1'b1;
              end
              SAMPLE_TICKS + 5'h05: begin
                s_nxt.sar[6] = s_r.compSync;
                s_nxt.sar[5] = 1'b1;
              end
              SAMPLE_TICKS + 5'h06: begin
                s_nxt.sar[5] = s_r.compSync;
                s_nxt.sar[4] = 1'b1;
              end
              SAMPLE_TICKS + 5'h07: begin
                s_nxt.sar[4] = s_r.compSync;
                s_nxt.sar[3] = 1'b1;
              end
              SAMPLE_TICKS + 5'h08: begin
                s_nxt.sar[3] = s_r.compSync;
                s_nxt.sar[2] = 1'b1;
              end
              SAMPLE_TICKS + 5'h09: begin
                s_nxt.sar[2] = s_r.compSync;
                s_nxt.sar[1] = 1'b1;
              end
              SAMPLE_TICKS + 5'h0a: begin
                s_nxt.sar[1] = s_r.compSync;
                s_nxt.sar[0] = 1'b1;
              end
              // Least significant bit has no lower trial
              SAMPLE_TICKS + 5'h0b: begin
                s_nxt.sar[0] = s_r.compSync;
              end
              default: begin
                s_nxt.sar = s_r.sar;
              end
            endcase
          end
          if (s_r.tickCnt + 5'h01 == CONV_TICKS) begin
            s_nxt.state = ST_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.result = s_nxt.sar;
            irqSet[IS_CONV_BIT] = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.state = ST_IDLE;
      end
    endcase

    // Setting wins over a clear in the same cycle
    s_nxt.irqStat = (s_r.irqStat & ~irqClr) | irqSet;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r.state <= ST_IDLE;
      s_r.chan <= 3'h0;
      s_r.pinCfg <= 3'h0;
      s_r.start <= 1'b0;
      s_r.busy <= RST_BUSY;
      s_r.powerDown <= RST_POWER_DOWN;
      s_r.divSel <= RST_DIV;
      s_r.globalEn <= 1'b0;
      s_r.multiEn <= 1'b0;
      s_r.irqStat <= 8'h00;
      s_r.irqMask <= RST_IRQ_MASK;
      s_r.result <= 12'h000;
      s_r.sar <= 12'h000;
      s_r.divCnt <= 6'h00;
      s_r.tickCnt <= 5'h00;
      s_r.sample <= 1'b0;
      s_r.rdata <= 8'h00;
      s_r.compMeta <= 1'b0;
      s_r.compSync <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign busRdata = s_r.rdata;

  // Mask register holds the converter enable bit
  assign irqPending = ((s_r.irqStat & s_r.irqMask) != 8'h00);
  assign irq = s_r.globalEn && s_r.multiEn && irqPending;

  always_comb begin
    coreCtl.powerOn = convOn;
    coreCtl.convReset = (s_r.state == ST_HOLD);
    coreCtl.sample = s_r.sample;
    coreCtl.chanSel = 8'h00;
    case (s_r.chan)
      3'h0: begin
        coreCtl.chanSel[0] = convOn;
      end
      3'h1: begin
        coreCtl.chanSel[1] = convOn;
      end
      3'h2: begin
        coreCtl.chanSel[2] = convOn;
      end
      3'h3: begin
        coreCtl.chanSel[3] = convOn;
      end
      3'h4: begin
        coreCtl.chanSel[4] = convOn;
      end
      3'h5: begin
        coreCtl.chanSel[5] = convOn;
      end
      3'h6: begin
        coreCtl.chanSel[6] = convOn;
      end
      default: begin
        coreCtl.chanSel[7] = convOn;
      end
    endcase
    coreCtl.dacCode = s_r.sar;
    portCtl.analogMask = analogMask;
    // Analog pins lose pull-ups and are forced to input
    portCtl.pullEn = portReq.pullReq & ~analogMask;
    portCtl.dirIn = portReq.dirInReq | analogMask;
  end

endmodule : adc_sequencer_control

//--- verif/adc_seq_asserts.sv
`timescale 1ns/100ps
module adc_seq_asserts
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire reg_req_s busReq,
  input wire logic [7:0] busRdata,
  input wire port_req_s portReq,
  input wire port_ctl_s portCtl,
  input wire core_ctl_s coreCtl,
  input wire logic compHigh,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_pull;
    portCtl.pullEn == (portReq.pullReq & ~portCtl.analogMask);
  endproperty
  a_pull: assert property (p_pull)
    else $error("pull enable wrong");
  property p_dir;
    portCtl.dirIn == (portReq.dirInReq | portCtl.analogMask);
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction override wrong");
  property p_chanOne;
    $onehot0(coreCtl.chanSel);
  endproperty
  a_chanOne: assert property (p_chanOne)
    else $error("more than one channel routed");
  property p_offChan;
    !coreCtl.powerOn |-> coreCtl.chanSel == 8'h00;
  endproperty
  a_offChan: assert property (p_offChan)
    else $error("channel routed while off");
  property p_maskRun;
    (portCtl.analogMask & (portCtl.analogMask + 8'h01)) == 8'h00;
  endproperty
  a_maskRun: assert property (p_maskRun)
    else $error("analog pins not contiguous");
  property p_noPins;
    portCtl.analogMask == 8'h00 |-> !coreCtl.powerOn;
  endproperty
  a_noPins: assert property (p_noPins)
    else $error("powered with no analog pins");
  property p_hold;
    coreCtl.convReset |-> !coreCtl.sample;
  endproperty
  a_hold: assert property (p_hold)
    else $error("sampling while held in reset");
  property p_begin;
    $fell(coreCtl.convReset) && coreCtl.powerOn |-> coreCtl.sample;
  endproperty
  a_begin: assert property (p_begin)
    else $error("conversion did not begin");
  property p_rdIdle;
    !busReq.rd |=> busRdata == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle)
    else $error("read data outside read slot");
  property p_irqEn;
    busReq.wr && busReq.addr == OFS_IRQ_CONTROL &&
      busReq.wdata[1:0] != 2'b11 |=> !irq;
  endproperty
  a_irqEn: assert property (p_irqEn)
    else $error("interrupt with enables off");
  c_sample: cover property ($rose(coreCtl.sample));
  c_irq: cover property ($rose(irq));
  c_read: cover property (busReq.rd ##1 busRdata != 8'h00);
endmodule : adc_seq_asserts

bind adc_sequencer_control adc_seq_asserts u_adc_seq_asserts(
  .clk(clk), .arst_n(arst_n), .busReq(busReq), .busRdata(busRdata),
  .portReq(portReq), .portCtl(portCtl), .coreCtl(coreCtl),
  .compHigh(compHigh), .irq(irq));

//--- verif/adc_core_model.sv
`timescale 1ns/100ps
module adc_core_model
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire core_ctl_s coreCtl,
  input wire logic [7:0][11:0] analogIn,
  output logic compHigh
);
  logic [11:0] level;
  logic junk = 1'b0;

  always @(posedge clk) junk <= ~junk;

  always_comb begin
    level = 12'h000;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if (coreCtl.chanSel[i]) level = analogIn[i];
    end
  end

  // Unpowered or held comparator output is noise, not a stale level
  assign compHigh = (coreCtl.powerOn && !coreCtl.convReset) ?
    (level >= coreCtl.dacCode) : junk;
endmodule : adc_core_model

//--- verif/test_adc_sequencer_control.sv
`timescale 1ns/100ps
module test_adc_sequencer_control
  import adc_seq_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  reg_req_s busReq = '0;
  port_req_s portReq = '{8'ha5, 8'h3c};
  logic [7:0][11:0] analogIn;
  logic [7:0] busRdata;
  port_ctl_s portCtl;
  core_ctl_s coreCtl;
  logic compHigh;
  logic irq;
  int errTotal = 0;
  int totalChecks = 0;
  int cyc = 0;
  int n;
  // Code 000 and 100 are too fast at this clock
  int ratio [6] = '{8, 32, 4, 16, 32, 32};
  logic [2:0] code [6] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7, 3'h3};

  always #50 clk = ~clk;

  adc_sequencer_control u_adc_sequencer_control(.clk(clk),
    .arst_n(arst_n), .busReq(busReq), .busRdata(busRdata),
    .portReq(portReq), .portCtl(portCtl), .coreCtl(coreCtl),
    .compHigh(compHigh), .irq(irq));
  adc_core_model u_adc_core_model(.clk(clk), .coreCtl(coreCtl),
    .analogIn(analogIn), .compHigh(compHigh));

  task end_sim;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      errTotal++;
      end_sim();
    end
  end

  task chk(input logic [15:0] g, input logic [15:0] e);
    totalChecks++;
    if (g !== e) begin
      errTotal++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    busReq <= '0;
  endtask : wr

  task rdChk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    busReq <= '0;
    #1 chk({8'h00, busRdata}, {8'h00, e});
  endtask : rdChk

  task conv(input logic [2:0] ch, input int r);
    wr(OFS_CONV_CONTROL, {PIN_ALL, 2'b10, ch});
    #1 chk(16'(coreCtl.convReset), 16'h1);
    rdChk(OFS_CONV_CONTROL, {PIN_ALL, 2'b11, ch});
    wr(OFS_CONV_CONTROL, {PIN_ALL, 2'b00, ch});
    rdChk(OFS_CONV_CONTROL, {PIN_ALL, 2'b01, ch});
    n = 2;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
      #1;
    end
    chk(16'(n), 16'(16 * r));
    rdChk(OFS_RESULT_HIGH, analogIn[ch][11:4]);
    rdChk(OFS_RESULT_LOW, {analogIn[ch][3:0], 4'h0});
    rdChk(OFS_CONV_CONTROL, {PIN_ALL, 2'b00, ch});
    rdChk(OFS_IRQ_STATUS, 8'h01);
    wr(OFS_IRQ_STATUS, 8'h01);
    #1 chk(16'(irq), 16'h0);
  endtask : conv

  initial begin
    analogIn = {12'hfff, 12'h001, 12'h800, 12'h7ff, 12'ha5c, 12'h3c5,
      12'h5a3, 12'h000};
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rdChk(OFS_CONV_CONTROL, 8'h00);
    rdChk(OFS_CLOCK_POWER_SELECT, 8'h80);
    for (int a = 4; a < 8; a++) rdChk(3'(a), 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(OFS_CONV_CONTROL, {3'(k), 5'h00});
      #1 chk(16'(portCtl.analogMask), 16'(k == 0 ? 0 : k >= 5 ? 255 :
        (1 << (k + 3)) - 1));
      chk(16'(coreCtl.powerOn), 16'h0);
    end
    wr(OFS_CLOCK_POWER_SELECT, 8'h01);
    #1 chk(16'(coreCtl.powerOn), 16'h1);
    wr(OFS_IRQ_CONTROL, 8'h03);
    wr(OFS_IRQ_MASK, 8'h01);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CLOCK_POWER_SELECT, {5'h00, code[i]});
      conv(3'(i), ratio[i]);
    end
    wr(OFS_RESULT_HIGH, 8'h00);
    rdChk(OFS_RESULT_HIGH, 8'h80);
    wr(OFS_IRQ_MASK, 8'h00);
    wr(OFS_CONV_CONTROL, {PIN_ALL, 2'b10, 3'h7});
    wr(OFS_CONV_CONTROL, {PIN_ALL, 2'b00, 3'h7});
    repeat (16 * 32 + 2) @(posedge clk);
    #1 chk(16'(irq), 16'h0);
    rdChk(OFS_IRQ_STATUS, 8'h01);
    wr(OFS_IRQ_MASK, 8'h01);
    #1 chk(16'(irq), 16'h1);
    wr(OFS_IRQ_CONTROL, 8'h01);
    #1 chk(16'(irq), 16'h0);
    rdChk(OFS_RESULT_HIGH, 8'hff);
    wr(OFS_CONV_CONTROL, 8'h10);
    wr(OFS_CONV_CONTROL, 8'h00);
    rdChk(OFS_CONV_CONTROL, 8'h08);
    end_sim();
  end
endmodule : test_adc_sequencer_control
